// ---- fault_capture_pkg.sv ----
package fault_capture_pkg;
  localparam logic [11:0] hard_fault_status_off    = 12'hd2c;
  localparam logic [11:0] memory_fault_address_off = 12'hd34;
  localparam logic [11:0] bus_fault_address_off    = 12'hd38;
  localparam int          addr_w                   = 12;
  localparam int          data_w                   = 32;
  localparam int          debug_event_bit          = 31;
  localparam int          hard_fault_flag_a_bit               = 30;
  localparam int          vector_bit               = 1;
  localparam int          priv_bit                 = 0;
  localparam int          byte_w                   = 8;
  localparam logic [31:0] zero_word                = 32'h0000_0000;
  localparam logic [2:0]  size_byte                = 3'h0;
  localparam logic [2:0]  size_half                = 3'h1;
  localparam logic [2:0]  size_word                = 3'h2;
  typedef enum logic [1:0] {
    bus_idle,
    bus_access
  } bus_state_e;
endpackage

// ---- fault_address_latch.sv ----
`timescale 1ns/100ps
module fault_address_latch #(
  parameter int width = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             capture,
  input  wire logic [width-1:0] capture_addr,
  input  wire logic             sw_write,
  input  wire logic [width-1:0] sw_data,
  output logic      [width-1:0] value_q
);
  typedef struct packed {
    logic [width-1:0] value;
  } latch_s;

  latch_s state_q;
  latch_s state_d;

  // hardware capture beats a software write in the same cycle
  always_comb begin
    state_d = state_q;
    if (capture) begin
      state_d.value = capture_addr;
    end else if (sw_write) begin
      state_d.value = sw_data;
    end
  end

  // no defined reset value: contents mean nothing until a capture
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  assign value_q = state_q.value;
endmodule

// ---- fault_status_address_capture.sv ----
`timescale 1ns/100ps
module fault_status_address_capture #(
  parameter int addr_w = fault_capture_pkg::addr_w
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [2:0]  pprot,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        vector_fetch_active,
  input  wire logic        vector_fetch_bus_error,
  input  wire logic        escalate_to_hard_fault,
  input  wire logic        debug_event,
  input  wire logic        exception_entry,
  input  wire logic [31:0] preempted_pc,
  input  wire logic [31:0] faulting_pc,
  input  wire logic        mem_fault_event,
  input  wire logic [31:0] mem_fault_actual_addr,
  input  wire logic        bus_fault_event,
  input  wire logic [31:0] bus_fault_request_addr,
  output logic             vector_fault_to_hard_fault,
  output logic      [31:0] stacked_return_pc,
  output logic             memory_fault_address_valid,
  output logic             bus_fault_address_valid
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    fault_capture_pkg::bus_state_e bus;
    logic                          ready;
    logic                          slverr;
    logic [31:0]                   rdata;
    logic                          debug_event_flag;
    logic                          hard_fault_flag_a;
    logic                          vector_read_fault_flag;
    logic                          route_hard;
    logic [31:0]                   return_pc;
    logic                          mem_valid;
    logic                          bus_valid;
  } state_s;

  state_s state_q;
  state_s state_d;

  logic [31:0] memory_fault_address_q;
  logic [31:0] bus_fault_address_q;
  logic [31:0] mem_sw_word;
  logic [31:0] bus_sw_word;
  logic [31:0] status_rd;
  logic        vector_error;
  logic        privileged;
  logic        in_access;
  logic        commit;
  logic        commit_write;
  logic        sel_status;
  logic        sel_mem_addr;
  logic        sel_bus_addr;
  logic        wr_status;
  logic        wr_mem_addr;
  logic        wr_bus_addr;
  logic        clr_debug;
  logic        clr_hard_fault_flag_a;
  logic        clr_vector;

  function automatic logic hit(input logic [31:0] a, input logic [11:0] off);
    hit = (a[11:0] == off);
  endfunction

  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strobe_merge = r;
  endfunction

  // each status bit is guarded by the strobe of the byte lane it sits in
  function automatic logic lane_on(input logic [3:0] strb, input int bit_pos);
    lane_on = strb[bit_pos / fault_capture_pkg::byte_w];
  endfunction

  // reserved bits stay zero, only the three flags show
  function automatic logic [31:0] status_word(input logic dbg, input logic frc, input logic vec);
    logic [31:0] w;
    w                                     = fault_capture_pkg::zero_word;
    w[fault_capture_pkg::debug_event_bit] = dbg;
    w[fault_capture_pkg::hard_fault_flag_a_bit]      = frc;
    w[fault_capture_pkg::vector_bit]      = vec;
    status_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign vector_error = vector_fetch_active & vector_fetch_bus_error;
  assign privileged   = pprot[fault_capture_pkg::priv_bit];
  assign in_access    = psel & penable & (state_q.bus == fault_capture_pkg::bus_access);
  // write lands only at the pready edge: a capture in the wait cycle is overwritten by it, one in the pready cycle wins
  assign commit       = in_access & state_q.ready;
  assign commit_write = commit & pwrite & privileged;
  assign sel_status   = hit(paddr, fault_capture_pkg::hard_fault_status_off);
  assign sel_mem_addr = hit(paddr, fault_capture_pkg::memory_fault_address_off);
  assign sel_bus_addr = hit(paddr, fault_capture_pkg::bus_fault_address_off);
  assign wr_status    = commit_write & sel_status;
  assign wr_mem_addr  = commit_write & sel_mem_addr;
  assign wr_bus_addr  = commit_write & sel_bus_addr;
  assign clr_debug    = wr_status & lane_on(pstrb, fault_capture_pkg::debug_event_bit)
                        & pwdata[fault_capture_pkg::debug_event_bit];
  assign clr_hard_fault_flag_a   = wr_status & lane_on(pstrb, fault_capture_pkg::hard_fault_flag_a_bit)
                        & pwdata[fault_capture_pkg::hard_fault_flag_a_bit];
  assign clr_vector   = wr_status & lane_on(pstrb, fault_capture_pkg::vector_bit)
                        & pwdata[fault_capture_pkg::vector_bit];
  assign mem_sw_word  = strobe_merge(memory_fault_address_q, pwdata, pstrb);
  assign bus_sw_word  = strobe_merge(bus_fault_address_q, pwdata, pstrb);
  assign status_rd    = status_word(state_q.debug_event_flag, state_q.hard_fault_flag_a,
                                    state_q.vector_read_fault_flag);

  fault_address_latch #(
    .width(fault_capture_pkg::data_w)
  ) u_mem_addr (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .capture      (mem_fault_event),
    .capture_addr (mem_fault_actual_addr),
    .sw_write     (wr_mem_addr),
    .sw_data      (mem_sw_word),
    .value_q      (memory_fault_address_q)
  );

  fault_address_latch #(
    .width(fault_capture_pkg::data_w)
  ) u_bus_addr (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .capture      (bus_fault_event),
    .capture_addr (bus_fault_request_addr),
    .sw_write     (wr_bus_addr),
    .sw_data      (bus_sw_word),
    .value_q      (bus_fault_address_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d        = state_q;
    state_d.ready  = 1'b0;
    state_d.slverr = 1'b0;
    state_d.route_hard = vector_error;

    if (exception_entry) begin
      state_d.return_pc = (vector_error | state_q.vector_read_fault_flag) ? preempted_pc : faulting_pc;
    end

    // valid flags mirror captures; cleared by a software write to the address
    if (wr_mem_addr) begin
      state_d.mem_valid = 1'b0;
    end
    if (mem_fault_event) begin
      state_d.mem_valid = 1'b1;
    end
    if (wr_bus_addr) begin
      state_d.bus_valid = 1'b0;
    end
    if (bus_fault_event) begin
      state_d.bus_valid = 1'b1;
    end

    // w1c clears first so a same-cycle event wins
    if (clr_debug) begin
      state_d.debug_event_flag = 1'b0;
    end
    if (clr_hard_fault_flag_a) begin
      state_d.hard_fault_flag_a = 1'b0;
    end
    if (clr_vector) begin
      state_d.vector_read_fault_flag = 1'b0;
    end
    if (debug_event) begin
      state_d.debug_event_flag = 1'b1;
    end
    if (escalate_to_hard_fault) begin
      state_d.hard_fault_flag_a = 1'b1;
    end
    if (vector_error) begin
      state_d.vector_read_fault_flag = 1'b1;
    end

    case (state_q.bus)
      fault_capture_pkg::bus_idle: begin
        if (psel & ~penable) begin
          state_d.bus = fault_capture_pkg::bus_access;
        end
      end
      fault_capture_pkg::bus_access: begin
        // one wait state: answer registered so outputs come from flops
        if (~state_q.ready) begin
          state_d.ready = 1'b1;
          state_d.rdata = fault_capture_pkg::zero_word;
          if (~privileged) begin
            state_d.slverr = 1'b1;
          end else if (sel_status) begin
            state_d.rdata = status_rd;
          end else if (sel_mem_addr) begin
            state_d.rdata = memory_fault_address_q;
          end else if (sel_bus_addr) begin
            state_d.rdata = bus_fault_address_q;
          end else begin
            state_d.slverr = 1'b1;
          end
          if (pwrite) begin
            state_d.rdata = fault_capture_pkg::zero_word;
          end
        end else begin
          state_d.bus = fault_capture_pkg::bus_idle;
        end
      end
      default: begin
        state_d.bus = fault_capture_pkg::bus_idle;
      end
    endcase

    if (~reset_n) begin
      state_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pready                     = state_q.ready;
  assign prdata                     = state_q.rdata;
  assign pslverr                    = state_q.slverr;
  assign vector_fault_to_hard_fault = state_q.route_hard;
  assign stacked_return_pc          = state_q.return_pc;
  assign memory_fault_address_valid = state_q.mem_valid;
  assign bus_fault_address_valid    = state_q.bus_valid;
endmodule

// ---- fault_capture_assertions.sv ----
`timescale 1ns/100ps
module fault_capture_assertions (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [2:0]  pprot,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        vector_fetch_active,
  input wire logic        vector_fetch_bus_error,
  input wire logic        exception_entry,
  input wire logic [31:0] preempted_pc,
  input wire logic        mem_fault_event,
  input wire logic        bus_fault_event,
  input wire logic        vector_fault_to_hard_fault,
  input wire logic [31:0] stacked_return_pc,
  input wire logic        memory_fault_address_valid,
  input wire logic        bus_fault_address_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire vec_err = vector_fetch_active && vector_fetch_bus_error;
  ////////////////////////////////////////////////////////////////
  property p_vec_route; vec_err |=> vector_fault_to_hard_fault; endproperty
  property p_vec_quiet; !vec_err |=> !vector_fault_to_hard_fault; endproperty
  property p_pc_pre; exception_entry && vec_err |=> stacked_return_pc == $past(preempted_pc); endproperty
  property p_mvalid; mem_fault_event |=> memory_fault_address_valid; endproperty
  property p_bvalid; bus_fault_event |=> bus_fault_address_valid; endproperty
  // valid must survive any cycle without a software access
  property p_mhold; memory_fault_address_valid && !psel |=> memory_fault_address_valid; endproperty
  property p_priv; pready && !pprot[0] |-> pslverr && prdata == 32'h0; endproperty
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_vec_route: assert property (p_vec_route) else $error("vector error not routed");
  a_vec_quiet: assert property (p_vec_quiet) else $error("spurious hard fault route");
  a_pc_pre: assert property (p_pc_pre) else $error("stacked pc not preempted pc");
  a_mvalid: assert property (p_mvalid) else $error("memory address valid missing");
  a_bvalid: assert property (p_bvalid) else $error("bus address valid missing");
  a_mhold: assert property (p_mhold) else $error("memory address valid dropped");
  a_priv: assert property (p_priv) else $error("unprivileged access not refused");
  a_wait: assert property (p_wait) else $error("access answer timing wrong");
  c_vec: cover property (vec_err);
  c_pc: cover property (exception_entry && vec_err);
  c_err: cover property (pready && pslverr);
endmodule

bind fault_status_address_capture fault_capture_assertions i_fault_capture_assertions (.*);

// ---- fault_status_address_capture_test.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("wrong value at %0t: %h %h", $time, a, b); end end
`define EVS {vector_fetch_active, vector_fetch_bus_error, escalate_to_hard_fault, debug_event, exception_entry, mem_fault_event, bus_fault_event}
module fault_status_address_capture_test;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
  logic        vector_fetch_active, vector_fetch_bus_error, escalate_to_hard_fault;
  logic        debug_event, exception_entry, mem_fault_event, bus_fault_event;
  logic        vector_fault_to_hard_fault, memory_fault_address_valid, bus_fault_address_valid;
  logic [31:0] paddr, pwdata, prdata, preempted_pc, faulting_pc, stacked_return_pc, r;
  logic [31:0] mem_fault_actual_addr, bus_fault_request_addr;
  logic [3:0]  pstrb;
  logic [2:0]  pprot;
  int          err_count = 0;
  int          n_tests = 0;

  fault_status_address_capture i_fault_status_address_capture (.*);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  // pready is read before the edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] pr);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    pprot <= pr;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 3'h1);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 3'h1);
    `CHK(r, x)
    `CHK(e, 1'b0)
  endtask
  task automatic ev(input logic [6:0] v);
    @(posedge sys_clk);
    `EVS <= v;
    @(posedge sys_clk);
    `EVS <= 7'h0;
    @(negedge sys_clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    `EVS = 7'h0;
    pstrb = 4'hf;
    pprot = 3'h1;
    preempted_pc = 32'h0000_1a40;
    faulting_pc = 32'h0000_2b80;
    mem_fault_actual_addr = 32'h2000_0103;
    bus_fault_request_addr = 32'h2000_0101;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    `CHK({memory_fault_address_valid, bus_fault_address_valid, vector_fault_to_hard_fault}, 3'h0)
    rdchk(12'hd2c, 32'h0);
    ev(7'h60);
    `CHK(vector_fault_to_hard_fault, 1'b1)
    rdchk(12'hd2c, 32'h2);
    wr(12'hd2c, 32'h0);
    rdchk(12'hd2c, 32'h2);
    wr(12'hd2c, 32'h2);
    rdchk(12'hd2c, 32'h0);
    ev(7'h10);
    `CHK(vector_fault_to_hard_fault, 1'b0)
    wr(12'hd2c, 32'hbfff_ffff);
    rdchk(12'hd2c, 32'h4000_0000);
    wr(12'hd2c, 32'h4000_0000);
    rdchk(12'hd2c, 32'h0);
    ev(7'h08);
    rdchk(12'hd2c, 32'h8000_0000);
    wr(12'hd2c, 32'hffff_ffff);
    ev(7'h64);
    `CHK(stacked_return_pc, preempted_pc)
    wr(12'hd2c, 32'h2);
    ev(7'h04);
    `CHK(stacked_return_pc, faulting_pc)
    ev(7'h03);
    `CHK({memory_fault_address_valid, bus_fault_address_valid}, 2'h3)
    rdchk(12'hd34, mem_fault_actual_addr);
    rdchk(12'hd38, bus_fault_request_addr);
    wr(12'hd34, 32'hcafe_0004);
    rdchk(12'hd34, 32'hcafe_0004);
    `CHK(memory_fault_address_valid, 1'b0)
    pstrb <= 4'h3;
    wr(12'hd38, 32'h1234_5678);
    pstrb <= 4'hf;
    rdchk(12'hd38, 32'h2000_5678);
    `CHK(bus_fault_address_valid, 1'b0)
    apb(1'b1, 12'hd34, 32'h0, 3'h0);
    `CHK(e, 1'b1)
    apb(1'b0, 12'hd34, 32'h0, 3'h2);
    `CHK({e, r}, {1'b1, 32'h0})
    rdchk(12'hd34, 32'hcafe_0004);
    apb(1'b0, 12'hd30, 32'h0, 3'h1);
    `CHK(e, 1'b1)
    conclude();
  end

  // the sequence needs well under 2000 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
endmodule
